// File: logic/sfrb_bank.sv
// Implementation choice: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module sfrb_bank
   import sfrb_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic irq,
   input wire logic t2_trigger_pin,
   input wire logic t2_count_input,
   input wire logic timing_pulse,
   input wire logic timer1_overflow,
   input wire logic spi_busy,
   output logic rx_baud_tick,
   output logic tx_baud_tick,
   output logic eeprom_access_enable,
   output logic eeprom_write_enable,
   output logic pointer_bank_select,
   output logic [15:0] data_pointer
);
   typedef struct packed {
      sfrb_state_t st;
      logic [31:0] rdata;
      logic [7:0] sp, data_ptr0_low, data_ptr0_high, data_ptr1_low, data_ptr1_high, pwr, tctl, tmode, tl0, tl1, th0, th1;
      logic [7:0] p0, p1, p2, p3, wmc, sctl, serial_port_buffer, ien, sps, ipr;
      logic [7:0] t2c, t2m, capl, caph, t2l, t2h, program_status_word, spc, acc, b;
      logic [2:0] istat, imask;
      logic trig_d, cnt_d, ovf_d;
   } sfrb_regs_t;

   sfrb_regs_t s_reg, s_next;
   logic [7:0] spd_reg;
   logic [7:0] rd_mux;
   logic acc_go, wr_go;
   logic [7:0] wb;
   logic baud_use, trig_fall, cnt_fall, tick, t2_ovf;
   logic [15:0] t2_cnt;

   // ****************************************
   // Address decode
   // ****************************************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      return a == r;
   endfunction : hit

   assign acc_go = (read | write) && s_reg.st == SFRB_IDLE;
   // Write lands at the edge that ends the wait, as the master sees it
   assign wr_go = write && s_reg.st == SFRB_ACK && byteenable[0];
   assign wb = writedata[7:0];
   assign waitrequest = (read | write) && s_reg.st == SFRB_IDLE;
   assign readdata = s_reg.rdata;

   always_comb begin
      rd_mux = 8'h00; // Unassigned reads give zero [RULE1]
      case (address) // Full 8-bit decode [RULE19]
         ADR_P0: rd_mux = s_reg.p0;
         ADR_SP: rd_mux = s_reg.sp;
         ADR_DATA_PTR0_LOW: rd_mux = s_reg.data_ptr0_low;
         ADR_DATA_PTR0_HIGH: rd_mux = s_reg.data_ptr0_high;
         ADR_DATA_PTR1_LOW: rd_mux = s_reg.data_ptr1_low;
         ADR_DATA_PTR1_HIGH: rd_mux = s_reg.data_ptr1_high;
         ADR_SPD: rd_mux = spd_reg;
         ADR_PWR: rd_mux = s_reg.pwr;
         ADR_TCTL: rd_mux = s_reg.tctl;
         ADR_TMODE: rd_mux = s_reg.tmode;
         ADR_TL0: rd_mux = s_reg.tl0;
         ADR_TL1: rd_mux = s_reg.tl1;
         ADR_TH0: rd_mux = s_reg.th0;
         ADR_TH1: rd_mux = s_reg.th1;
         ADR_P1: rd_mux = s_reg.p1;
         ADR_WMC: rd_mux = s_reg.wmc;
         ADR_SCTL: rd_mux = s_reg.sctl;
         ADR_SERIAL_PORT_BUFFER: rd_mux = s_reg.serial_port_buffer;
         ADR_P2: rd_mux = s_reg.p2;
         ADR_IEN: rd_mux = s_reg.ien;
         ADR_SPS: rd_mux = s_reg.sps;
         ADR_P3: rd_mux = s_reg.p3;
         ADR_IPR: rd_mux = s_reg.ipr;
         ADR_T2C: rd_mux = s_reg.t2c;
         ADR_T2M: rd_mux = s_reg.t2m;
         ADR_CAPL: rd_mux = s_reg.capl;
         ADR_CAPH: rd_mux = s_reg.caph;
         ADR_T2L: rd_mux = s_reg.t2l;
         ADR_T2H: rd_mux = s_reg.t2h;
         ADR_PSW: rd_mux = s_reg.program_status_word;
         ADR_SPC: rd_mux = s_reg.spc;
         ADR_ACC: rd_mux = s_reg.acc;
         ADR_B: rd_mux = s_reg.b;
         ADR_IRQ_STAT: rd_mux = {5'h00, s_reg.istat};
         ADR_IRQ_MASK: rd_mux = {5'h00, s_reg.imask};
         default: rd_mux = 8'h00;
      endcase
   end

   // ****************************************
   // Timer 2 control semantics
   // ****************************************
   assign baud_use = s_reg.t2c[T2_RCLK] | s_reg.t2c[T2_TX_BAUD_SOURCE_SELECT];
   assign trig_fall = s_reg.trig_d & ~t2_trigger_pin;
   assign cnt_fall = s_reg.cnt_d & ~t2_count_input;
   // Pulses or external falling edges, gated by run [RULE15] [RULE16]
   assign tick = s_reg.t2c[T2_RUN] &
      (s_reg.t2c[T2_CT] ? cnt_fall : timing_pulse);
   assign t2_cnt = {s_reg.t2h, s_reg.t2l};
   assign t2_ovf = tick && t2_cnt == 16'hFFFF;
   // Baud tick source per direction [RULE12] [RULE13]
   assign rx_baud_tick = s_reg.t2c[T2_RCLK] ? s_reg.ovf_d : timer1_overflow;
   assign tx_baud_tick = s_reg.t2c[T2_TX_BAUD_SOURCE_SELECT] ? s_reg.ovf_d : timer1_overflow;
   // Memory control outputs [RULE7]
   assign eeprom_access_enable = s_reg.wmc[WMC_EEPROM_ACCESS_ENABLE];
   assign eeprom_write_enable = s_reg.wmc[WMC_EEPROM_WRITE_ENABLE];
   assign pointer_bank_select = s_reg.wmc[WMC_DPS];
   assign data_pointer = s_reg.wmc[WMC_DPS] ? {s_reg.data_ptr1_high, s_reg.data_ptr1_low} :
      {s_reg.data_ptr0_high, s_reg.data_ptr0_low};
   assign irq = |(s_reg.istat & s_reg.imask);

   always_comb begin
      logic ext_ev, ovf_set, ext_set, write_collision_flag_set;
      logic [15:0] nc;
      s_next = s_reg;
      ext_ev = 1'b0;
      ovf_set = 1'b0;
      ext_set = 1'b0;
      write_collision_flag_set = 1'b0;
      nc = t2_cnt;
      s_next.trig_d = t2_trigger_pin;
      s_next.cnt_d = t2_count_input;
      s_next.ovf_d = t2_ovf;
      s_next.st = acc_go ? SFRB_ACK : SFRB_IDLE;
      if (acc_go && read) begin
         s_next.rdata = {24'h000000, rd_mux};
      end
      if (wr_go) begin
         case (address) // Unassigned writes dropped [RULE1] [RULE19]
            ADR_P0: s_next.p0 = wb;
            ADR_SP: s_next.sp = wb;
            ADR_DATA_PTR0_LOW: s_next.data_ptr0_low = wb;
            ADR_DATA_PTR0_HIGH: s_next.data_ptr0_high = wb;
            ADR_DATA_PTR1_LOW: s_next.data_ptr1_low = wb;
            ADR_DATA_PTR1_HIGH: s_next.data_ptr1_high = wb;
            ADR_PWR: s_next.pwr = wb;
            ADR_TCTL: s_next.tctl = wb;
            ADR_TMODE: s_next.tmode = wb;
            ADR_TL0: s_next.tl0 = wb;
            ADR_TL1: s_next.tl1 = wb;
            ADR_TH0: s_next.th0 = wb;
            ADR_TH1: s_next.th1 = wb;
            ADR_P1: s_next.p1 = wb;
            ADR_WMC: s_next.wmc = wb; // [RULE7]
            ADR_SCTL: s_next.sctl = wb;
            ADR_SERIAL_PORT_BUFFER: s_next.serial_port_buffer = wb;
            ADR_P2: s_next.p2 = wb;
            ADR_IEN: s_next.ien = wb; // [RULE6]
            ADR_SPS: s_next.sps = wb;
            ADR_P3: s_next.p3 = wb;
            ADR_IPR: s_next.ipr = {2'h0, wb[5:0]}; // Six sources [RULE6]
            ADR_T2C: s_next.t2c = wb; // [RULE9]
            ADR_T2M: s_next.t2m = wb;
            ADR_CAPL: s_next.capl = wb;
            ADR_CAPH: s_next.caph = wb;
            ADR_PSW: s_next.program_status_word = wb;
            ADR_SPC: s_next.spc = wb; // [RULE6]
            ADR_ACC: s_next.acc = wb;
            ADR_B: s_next.b = wb;
            ADR_IRQ_MASK: s_next.imask = wb[2:0];
            ADR_IRQ_STAT: s_next.istat = s_reg.istat & ~wb[2:0];
            default: ;
         endcase
      end
      // Trigger edges only with enable and no baud use [RULE14]
      ext_ev = trig_fall && s_reg.t2c[T2_EXEN] && !baud_use;
      if (tick) begin
         nc = t2_cnt + 16'h0001;
      end
      if (t2_ovf) begin
         nc = {s_reg.caph, s_reg.capl}; // Reload from capture pair on every overflow, baud use or not [RULE18]
         ovf_set = !baud_use; // [RULE10]
      end
      if (ext_ev) begin
         ext_set = 1'b1; // [RULE11]
         if (s_reg.t2c[T2_CPRL]) begin
            s_next.caph = t2_cnt[15:8]; // Capture [RULE8] [RULE17]
            s_next.capl = t2_cnt[7:0];
         end else begin
            nc = {s_reg.caph, s_reg.capl}; // Reload [RULE8] [RULE17]
         end
      end
      if (!(wr_go && (address == ADR_T2L || address == ADR_T2H))) begin
         s_next.t2h = nc[15:8];
         s_next.t2l = nc[7:0];
      end else if (address == ADR_T2L) begin
         s_next.t2l = wb;
      end else begin
         s_next.t2h = wb;
      end
      // Hardware set wins over software clear
      if (ovf_set) begin
         s_next.t2c[T2_OVF] = 1'b1;
      end
      if (ext_set) begin
         s_next.t2c[T2_EXT] = 1'b1;
      end
      // Collision on data write mid transfer [RULE4]
      write_collision_flag_set = wr_go && hit(address, ADR_SPD) && spi_busy;
      if (write_collision_flag_set) begin
         s_next.sps[SPS_WRITE_COLLISION_FLAG] = 1'b1;
      end
      // Up/down mode keeps trigger flag out of interrupt [RULE11]
      s_next.istat = s_next.istat | {write_collision_flag_set,
         ext_set && !s_reg.t2m[T2M_UP_DOWN_COUNT_ENABLE], ovf_set};
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s_reg <= '0; // Most registers zero [RULE3]
         s_reg.p0 <= RST_PORT;
         s_reg.p1 <= RST_PORT;
         s_reg.p2 <= RST_PORT;
         s_reg.p3 <= RST_PORT;
         s_reg.sp <= RST_SP;
         s_reg.wmc <= RST_WMC;
         s_reg.spc <= RST_SPC;
         s_reg.t2c <= RST_ZERO; // [RULE9]
         s_reg.trig_d <= 1'b1;
         s_reg.cnt_d <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // Data register has no reset on purpose [RULE5]
   always_ff @(posedge clock) begin
      if (wr_go && hit(address, ADR_SPD)) begin
         spd_reg <= wb;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_ovf_set: assert property (@(posedge clock) disable iff (!rstn) // [RULE10]
      t2_ovf && !baud_use |=> s_reg.t2c[T2_OVF]) else $error("overflow flag missed");
   a_ovf_baud: assert property (@(posedge clock) disable iff (!rstn) // [RULE10]
      !s_reg.t2c[T2_OVF] && baud_use && !wr_go |=> !s_reg.t2c[T2_OVF])
      else $error("overflow flag set in baud use");
   a_ext_flag: assert property (@(posedge clock) disable iff (!rstn) // [RULE11]
      trig_fall && s_reg.t2c[T2_EXEN] && !baud_use |=> s_reg.t2c[T2_EXT])
      else $error("external flag missed");
   a_trig_off: assert property (@(posedge clock) disable iff (!rstn) // [RULE14]
      trig_fall && !s_reg.t2c[T2_EXEN] && !t2_ovf && !tick && !wr_go
      |=> $stable({s_reg.t2h, s_reg.t2l})) else $error("trigger not ignored");
   a_run_stop: assert property (@(posedge clock) disable iff (!rstn) // [RULE15]
      !s_reg.t2c[T2_RUN] && !trig_fall && !wr_go |=> $stable({s_reg.t2h, s_reg.t2l}))
      else $error("timer ran while stopped");
   a_capture: assert property (@(posedge clock) disable iff (!rstn) // [RULE17]
      trig_fall && s_reg.t2c[T2_EXEN] && s_reg.t2c[T2_CPRL] && !baud_use
      |=> {s_reg.caph, s_reg.capl} == $past(t2_cnt)) else $error("capture wrong");
   a_reload: assert property (@(posedge clock) disable iff (!rstn) // [RULE18]
      t2_ovf && !wr_go |=> {s_reg.t2h, s_reg.t2l} == $past({s_reg.caph, s_reg.capl}))
      else $error("reload wrong");
   a_write_collision_flag_set: assert property (@(posedge clock) disable iff (!rstn) // [RULE4]
      wr_go && address == ADR_SPD && spi_busy |=> s_reg.sps[SPS_WRITE_COLLISION_FLAG])
      else $error("collision flag missed");
   a_rx_src: assert property (@(posedge clock) disable iff (!rstn) // [RULE12]
      !s_reg.t2c[T2_RCLK] |-> rx_baud_tick == timer1_overflow)
      else $error("receive baud source wrong");
   a_bus_ack: assert property (@(posedge clock) disable iff (!rstn) // [RULE19]
      read && waitrequest |=> !waitrequest) else $error("bus not acknowledged");
   c_overflow: cover property (@(posedge clock) disable iff (!rstn) t2_ovf);
   c_capture: cover property (@(posedge clock) disable iff (!rstn)
      trig_fall && s_reg.t2c[T2_EXEN] && s_reg.t2c[T2_CPRL]);
   c_write_collision_flag: cover property (@(posedge clock) disable iff (!rstn)
      wr_go && address == ADR_SPD && spi_busy);
   c_irq: cover property (@(posedge clock) disable iff (!rstn) irq);

   // ****************************************
   // Baud source, flag, counter, priority and reset checks
   // ****************************************
   a_tx_src: assert property (@(posedge clock) disable iff (!rstn) // [RULE13]
      !s_reg.t2c[T2_TX_BAUD_SOURCE_SELECT] |-> tx_baud_tick == timer1_overflow)
      else $error("transmit baud source wrong");
   a_rx_t2: assert property (@(posedge clock) disable iff (!rstn) // [RULE12]
      t2_ovf && s_reg.t2c[T2_RCLK] && !wr_go |=> rx_baud_tick)
      else $error("receive baud tick missed");
   a_tx_t2: assert property (@(posedge clock) disable iff (!rstn) // [RULE13]
      t2_ovf && s_reg.t2c[T2_TX_BAUD_SOURCE_SELECT] && !wr_go |=> tx_baud_tick)
      else $error("transmit baud tick missed");
   a_ovf_hold: assert property (@(posedge clock) disable iff (!rstn) // [RULE10]
      s_reg.t2c[T2_OVF] && !(wr_go && address == ADR_T2C) |=> s_reg.t2c[T2_OVF])
      else $error("overflow flag lost");
   a_ext_hold: assert property (@(posedge clock) disable iff (!rstn) // [RULE11]
      s_reg.t2c[T2_EXT] && !(wr_go && address == ADR_T2C) |=> s_reg.t2c[T2_EXT])
      else $error("external flag lost");
   a_ext_irq: assert property (@(posedge clock) disable iff (!rstn) // [RULE11]
      trig_fall && s_reg.t2c[T2_EXEN] && !baud_use && !s_reg.t2m[T2M_UP_DOWN_COUNT_ENABLE]
      |=> s_reg.istat[IRQ_EXT]) else $error("external interrupt missed");
   a_ext_updown: assert property (@(posedge clock) disable iff (!rstn) // [RULE11]
      !s_reg.istat[IRQ_EXT] && s_reg.t2m[T2M_UP_DOWN_COUNT_ENABLE] |=> !s_reg.istat[IRQ_EXT])
      else $error("external interrupt in up/down mode");
   a_trig_reload: assert property (@(posedge clock) disable iff (!rstn) // [RULE17]
      trig_fall && s_reg.t2c[T2_EXEN] && !s_reg.t2c[T2_CPRL] && !baud_use && !wr_go
      |=> {s_reg.t2h, s_reg.t2l} == $past({s_reg.caph, s_reg.capl}))
      else $error("trigger reload wrong");
   a_count_step: assert property (@(posedge clock) disable iff (!rstn) // [RULE15]
      tick && !t2_ovf && !trig_fall && !wr_go
      |=> {s_reg.t2h, s_reg.t2l} == $past(t2_cnt) + 16'h0001)
      else $error("count step wrong");
   a_ct_gate: assert property (@(posedge clock) disable iff (!rstn) // [RULE16]
      s_reg.t2c[T2_CT] && !cnt_fall |-> !tick) else $error("counter mode took a pulse");
   a_ipr_top: assert property (@(posedge clock) disable iff (!rstn) // [RULE6]
      s_reg.ipr[7:6] == 2'h0) else $error("priority spare bits set");
   a_write_collision_flag_hold: assert property (@(posedge clock) disable iff (!rstn) // [RULE4]
      s_reg.sps[SPS_WRITE_COLLISION_FLAG] && !(wr_go && address == ADR_SPS) |=> s_reg.sps[SPS_WRITE_COLLISION_FLAG])
      else $error("collision flag lost");
   a_reset_vals: assert property (@(posedge clock) // [RULE3]
      $rose(rstn) |-> s_reg.p0 == RST_PORT && s_reg.sp == RST_SP && s_reg.wmc == RST_WMC
      && s_reg.t2c == RST_ZERO) else $error("reset values wrong");

   // ****************************************
   // Bus and decode checks
   // ****************************************
   // Separate decode, so a slip in the read mux cannot hide
   function automatic logic is_mapped(input logic [7:0] a);
      case (a)
         ADR_P0,
         ADR_SP,
         ADR_DATA_PTR0_LOW,
         ADR_DATA_PTR0_HIGH,
         ADR_DATA_PTR1_LOW,
         ADR_DATA_PTR1_HIGH,
         ADR_SPD,
         ADR_PWR,
         ADR_TCTL,
         ADR_TMODE,
         ADR_TL0,
         ADR_TL1,
         ADR_TH0,
         ADR_TH1,
         ADR_P1,
         ADR_WMC,
         ADR_SCTL,
         ADR_SERIAL_PORT_BUFFER,
         ADR_P2,
         ADR_IEN,
         ADR_SPS,
         ADR_P3,
         ADR_IPR,
         ADR_T2C,
         ADR_T2M,
         ADR_CAPL,
         ADR_CAPH,
         ADR_T2L,
         ADR_T2H,
         ADR_PSW,
         ADR_SPC,
         ADR_ACC,
         ADR_B,
         ADR_IRQ_STAT,
         ADR_IRQ_MASK: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : is_mapped

   a_unmapped_rd: assert property (@(posedge clock) disable iff (!rstn) // [RULE1]
      acc_go && read && !is_mapped(address) |=> readdata == 32'h00000000)
      else $error("unassigned read not zero");
   a_rdata_upper: assert property (@(posedge clock) disable iff (!rstn) // [RULE19]
      readdata[31:8] == 24'h000000) else $error("read data upper bits set");
   a_write_ack: assert property (@(posedge clock) disable iff (!rstn) // [RULE19]
      write && waitrequest |=> !waitrequest) else $error("write not acknowledged");
   c_unmapped: cover property (@(posedge clock) disable iff (!rstn)
      acc_go && read && !is_mapped(address));
endmodule : sfrb_bank

// File: logic/sfrb_pkg.sv
// Contract
// [RULE1] Unassigned addresses read zero, writes ignored
// [RULE2] Software writes no ones to unassigned
// [RULE3] Registers load documented values at reset
// [RULE4] Data write mid-transfer sets collision flag
// [RULE5] Serial data register keeps value over reset
// [RULE6] Enable and priority registers per source
// [RULE7] Memory control routes pointer, EEPROM, bank
// [RULE8] Capture pair takes capture, gives reload
// [RULE9] Timer control at C8, reset zero
// [RULE10] Overflow flag set unless baud use
// [RULE11] Trigger flag set on trigger event
// [RULE12] Receive baud source follows select bit
// [RULE13] Transmit baud source follows select bit
// [RULE14] Trigger edges act only when enabled
// [RULE15] Timer counts only while run set
// [RULE16] Counter select picks pulses or edges
// [RULE17] Capture select picks capture or reload
// [RULE18] Baud use forces auto reload
// [RULE19] Each address selects one register
package sfrb_pkg;
   localparam logic [7:0] ADR_P0 = 8'h80;
   localparam logic [7:0] ADR_SP = 8'h81;
   localparam logic [7:0] ADR_DATA_PTR0_LOW = 8'h82;
   localparam logic [7:0] ADR_DATA_PTR0_HIGH = 8'h83;
   localparam logic [7:0] ADR_DATA_PTR1_LOW = 8'h84;
   localparam logic [7:0] ADR_DATA_PTR1_HIGH = 8'h85;
   localparam logic [7:0] ADR_SPD = 8'h86;
   localparam logic [7:0] ADR_PWR = 8'h87;
   localparam logic [7:0] ADR_TCTL = 8'h88;
   localparam logic [7:0] ADR_TMODE = 8'h89;
   localparam logic [7:0] ADR_TL0 = 8'h8A;
   localparam logic [7:0] ADR_TL1 = 8'h8B;
   localparam logic [7:0] ADR_TH0 = 8'h8C;
   localparam logic [7:0] ADR_TH1 = 8'h8D;
   localparam logic [7:0] ADR_P1 = 8'h90;
   localparam logic [7:0] ADR_WMC = 8'h96;
   localparam logic [7:0] ADR_SCTL = 8'h98;
   localparam logic [7:0] ADR_SERIAL_PORT_BUFFER = 8'h99;
   localparam logic [7:0] ADR_P2 = 8'hA0;
   localparam logic [7:0] ADR_IEN = 8'hA8;
   localparam logic [7:0] ADR_SPS = 8'hAA;
   localparam logic [7:0] ADR_P3 = 8'hB0;
   localparam logic [7:0] ADR_IPR = 8'hB8;
   localparam logic [7:0] ADR_T2C = 8'hC8;
   localparam logic [7:0] ADR_T2M = 8'hC9;
   localparam logic [7:0] ADR_CAPL = 8'hCA;
   localparam logic [7:0] ADR_CAPH = 8'hCB;
   localparam logic [7:0] ADR_T2L = 8'hCC;
   localparam logic [7:0] ADR_T2H = 8'hCD;
   localparam logic [7:0] ADR_PSW = 8'hD0;
   localparam logic [7:0] ADR_SPC = 8'hD5;
   localparam logic [7:0] ADR_ACC = 8'hE0;
   localparam logic [7:0] ADR_B = 8'hF0;
   localparam logic [7:0] ADR_IRQ_STAT = 8'hFA;
   localparam logic [7:0] ADR_IRQ_MASK = 8'hFB;
   localparam logic [7:0] RST_PORT = 8'hFF;
   localparam logic [7:0] RST_SP = 8'h07;
   localparam logic [7:0] RST_WMC = 8'h02;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_SPC = 8'h04;
   localparam int T2_OVF = 7;
   localparam int T2_EXT = 6;
   localparam int T2_RCLK = 5;
   localparam int T2_TX_BAUD_SOURCE_SELECT = 4;
   localparam int T2_EXEN = 3;
   localparam int T2_RUN = 2;
   localparam int T2_CT = 1;
   localparam int T2_CPRL = 0;
   localparam int T2M_UP_DOWN_COUNT_ENABLE = 0;
   localparam int WMC_EEPROM_WRITE_ENABLE = 4;
   localparam int WMC_EEPROM_ACCESS_ENABLE = 3;
   localparam int WMC_DPS = 2;
   localparam int SPS_WRITE_COLLISION_FLAG = 6;
   localparam int IRQ_OVF = 0;
   localparam int IRQ_EXT = 1;
   localparam int IRQ_WRITE_COLLISION_FLAG = 2;
   localparam logic [1:0] IRQ_W = 2'h3;
   typedef enum logic [0:0] {SFRB_IDLE, SFRB_ACK} sfrb_state_t;
endpackage : sfrb_pkg

// File: bench/sfrb_cpu_model.sv
`timescale 1ns/10ps
// ************************************************
// CPU side of the register bus
// ************************************************
module sfrb_cpu_model (
   input wire logic clock,
   output logic [7:0] address = 8'h00,
   output logic read = 1'b0,
   output logic write = 1'b0,
   output logic [31:0] writedata = 32'h00000000,
   output logic [3:0] byteenable = 4'h0,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   output logic hung = 1'b0
);
   // Request held until waitrequest is seen low; no latency assumed
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
      int n;
      @(posedge clock);
      address <= a;
      read <= ~wr;
      write <= wr;
      writedata <= {24'h000000, d};
      byteenable <= 4'hF;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      if (waitrequest !== 1'b0) hung = 1'b1;
      q = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
   endtask : xfer
endmodule : sfrb_cpu_model

// File: bench/sfrb_bank_test.sv
`timescale 1ns/10ps
module sfrb_bank_test;
   import sfrb_pkg::*;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   // Trigger and count inputs idle high, like their pins
   logic [4:0] pins = 5'h06;
   logic [7:0] address;
   logic read;
   logic write;
   logic [31:0] writedata;
   logic [3:0] byteenable;
   logic [31:0] readdata;
   logic waitrequest;
   logic irq;
   logic rx_baud_tick;
   logic tx_baud_tick;
   logic eeprom_access_enable;
   logic eeprom_write_enable;
   logic pointer_bank_select;
   logic [15:0] data_pointer;
   logic hung;
   int miscompares = 0;
   int compares = 0;
   int rx_cnt = 0;
   int tx_cnt = 0;
   int rx0 = 0;
   int tx0 = 0;
   // Rows: {write, address, data}; read rows hold the reset value
   logic [24:0] rows [0:22] = '{25'h080FF, 25'h08107, 25'h08200, 25'h08800, 25'h090FF,
      25'h09602, 25'h09800, 25'h0A0FF, 25'h0B0FF, 25'h0C800, 25'h0CA00, 25'h0CD00,
      25'h0D000, 25'h0D504, 25'h0E000, 25'h0F000, 25'h0C000, 25'h181A5, 25'h1E05A,
      25'h1F0C3, 25'h1B83F, 25'h1C901, 25'h1C000};

   always #5 clock = ~clock;
   always @(posedge clock) begin
      if (rx_baud_tick === 1'b1) rx_cnt <= rx_cnt + 1;
      if (tx_baud_tick === 1'b1) tx_cnt <= tx_cnt + 1;
   end

   sfrb_bank dut (.clock(clock), .rstn(rstn), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .irq(irq), .t2_trigger_pin(pins[2]),
      .t2_count_input(pins[1]), .timing_pulse(pins[0]), .timer1_overflow(pins[3]),
      .spi_busy(pins[4]), .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick),
      .eeprom_access_enable(eeprom_access_enable), .eeprom_write_enable(eeprom_write_enable),
      .pointer_bank_select(pointer_bank_select), .data_pointer(data_pointer));
   sfrb_cpu_model cpu (.clock(clock), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .hung(hung));

   task automatic conclude;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : conclude
   task automatic chkv(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask : chkv
   task automatic chkf(input string nm, input logic e, input logic g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %b seen %b", nm, e, g);
      end
   endtask : chkf
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      cpu.xfer(1'b1, a, d, q);
      if (hung === 1'b1) begin
         miscompares++;
         conclude();
      end
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
      logic [7:0] q;
      cpu.xfer(1'b0, a, 8'h00, q);
      if (hung === 1'b1) begin
         miscompares++;
         conclude();
      end
      chkv($sformatf("reg %h", a), {8'h00, e}, {8'h00, q & m});
   endtask : rd
   // Inverts a pin for one cycle: a pulse, or a falling edge on an idle-high pin
   task automatic pulse(input int b);
      @(posedge clock);
      pins[b] <= ~pins[b];
      @(posedge clock);
      pins[b] <= ~pins[b];
      repeat (3) @(posedge clock);
   endtask : pulse
   task automatic ticks(input int n);
      chkv("rx ticks", 16'(n), 16'(rx_cnt - rx0));
      chkv("tx ticks", 16'(n), 16'(tx_cnt - tx0));
      rx0 = rx_cnt;
      tx0 = tx_cnt;
   endtask : ticks

   initial begin
      repeat (16) @(posedge clock);
      rstn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i][16]) wr(rows[i][15:8], rows[i][7:0]);
         rd(rows[i][15:8], rows[i][7:0]);
      end
      $display("test table done");
      wr(8'hFB, 8'h07);
      wr(8'hCC, 8'hFF);
      wr(8'hCD, 8'hFF);
      wr(8'hCA, 8'h34);
      wr(8'hCB, 8'h12);
      wr(8'hC8, 8'h00);
      pulse(0);
      rd(8'hCC, 8'hFF);
      wr(8'hC8, 8'h04);
      pulse(0);
      rd(8'hCC, 8'h34);
      rd(8'hCD, 8'h12);
      rd(8'hC8, 8'h84);
      chkf("irq", 1'b1, irq);
      ticks(0);
      wr(8'hFA, 8'h01);
      wr(8'hC8, 8'h04);
      rd(8'hC8, 8'h04);
      chkf("irq", 1'b0, irq);
      wr(8'hCC, 8'hFF);
      wr(8'hCD, 8'hFF);
      wr(8'hC8, 8'h35);
      pulse(0);
      rd(8'hC8, 8'h35);
      rd(8'hCC, 8'h34);
      ticks(1);
      wr(8'hC8, 8'h00);
      pulse(3);
      ticks(1);
      $display("test overflow done");
      wr(8'hCC, 8'h78);
      wr(8'hCD, 8'h56);
      wr(8'hC8, 8'h09);
      pulse(2);
      rd(8'hCA, 8'h78);
      rd(8'hCB, 8'h56);
      rd(8'hC8, 8'h49);
      chkf("irq", 1'b0, irq);
      wr(8'hC9, 8'h00);
      wr(8'hC8, 8'h01);
      wr(8'hCC, 8'h11);
      pulse(2);
      rd(8'hCA, 8'h78);
      rd(8'hC8, 8'h01);
      wr(8'hC8, 8'h08);
      pulse(2);
      rd(8'hCC, 8'h78);
      rd(8'hCD, 8'h56);
      rd(8'hC8, 8'h48);
      chkf("irq", 1'b1, irq);
      wr(8'hC8, 8'h18);
      wr(8'hCC, 8'h00);
      pulse(2);
      rd(8'hCC, 8'h00);
      rd(8'hC8, 8'h18);
      wr(8'hCD, 8'h00);
      wr(8'hC8, 8'h06);
      pulse(0);
      rd(8'hCC, 8'h00);
      pulse(1);
      rd(8'hCC, 8'h01);
      $display("test trigger done");
      wr(8'hFA, 8'h07);
      wr(8'hFB, 8'h00);
      @(posedge clock);
      pins[4] <= 1'b1;
      wr(8'h86, 8'h5A);
      rd(8'hAA, 8'h40, 8'h40);
      chkf("irq", 1'b0, irq);
      wr(8'hFB, 8'h04);
      rd(8'hFB, 8'h04);
      chkf("irq", 1'b1, irq);
      wr(8'hFA, 8'h04);
      rd(8'hFA, 8'h00, 8'h04);
      chkf("irq", 1'b0, irq);
      pins[4] <= 1'b0;
      $display("test collision done");
      wr(8'h82, 8'h11);
      wr(8'h83, 8'h22);
      wr(8'h84, 8'h33);
      wr(8'h85, 8'h44);
      wr(8'h96, 8'h1C);
      @(posedge clock);
      chkf("eeprom access", 1'b1, eeprom_access_enable);
      chkf("eeprom write", 1'b1, eeprom_write_enable);
      chkv("pointer", 16'h4433, data_pointer);
      wr(8'h96, 8'h02);
      @(posedge clock);
      chkf("bank", 1'b0, pointer_bank_select);
      chkv("pointer", 16'h2211, data_pointer);
      $display("test pointer done");
      wr(8'h86, 8'hA5);
      @(posedge clock);
      rstn <= 1'b0;
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      rd(8'h86, 8'hA5);
      rd(8'hC8, 8'h00);
      rd(8'h84, 8'h00);
      $display("test reset done");
      conclude();
   end
endmodule : sfrb_bank_test
